// *** hdl/bit_sync.sv ***
// two-flop synchroniser for a group of independent level inputs.
// assumes each bit is a slow level; no bit relation is kept across the group.
module bit_sync #(
  parameter int WIDTH = 1
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);

  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
  } sync_t;

  sync_t q;
  sync_t d;

  always_comb begin
    d = q;
    d.s1 = din;
    d.s2 = q.s1;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '0;
    end else if (ce) begin
      q <= d;
    end
  end

  assign dout = q.s2;

endmodule : bit_sync

// *** hdl/cc_channel.sv ***
// one capture/compare module: mode, compare pair, edge capture and pin logic.
// assumes count_now/count_next/tick come from the shared counter and pin_in
// is already synchronised; register write strobes are single-cycle pulses.
module cc_channel (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic tick,
  input wire logic [15:0] count_now,
  input wire logic [15:0] count_next,
  input wire logic pin_in,
  input wire logic wr_mode,
  input wire logic wr_low,
  input wire logic wr_high,
  input wire logic [7:0] wdata,
  output logic [7:0] mode,
  output logic [7:0] cmp_low,
  output logic [7:0] cmp_high,
  output logic pin_out,
  output logic pin_oe,
  output logic flag_set
);

  typedef struct packed {
    logic [7:0] mode;
    logic [7:0] low;
    logic [7:0] high;
    logic pin_prev;
    logic pin;
    logic oe;
  } ch_t;

  ch_t q;
  ch_t d;
  cca_pkg::cc_mode_t m;
  logic eq16;
  logic eq8;
  logic wrap16;
  logic wrap8;
  logic rise_e;
  logic fall_e;

  always_comb begin
    d = q;
    flag_set = 1'b0;
    m = cca_pkg::decode_mode(q.mode);
    eq16 = tick && count_next == {q.high, q.low};
    eq8 = tick && count_next[7:0] == q.low;
    wrap16 = tick && count_now == cca_pkg::COUNT_TOP;
    wrap8 = tick && count_now[7:0] == cca_pkg::LOW_TOP;
    rise_e = pin_in && !q.pin_prev;
    fall_e = !pin_in && q.pin_prev;
    d.pin_prev = pin_in;
    case (m)
      cca_pkg::M_CAPTURE: begin
        if ((q.mode[cca_pkg::MM_RISE] && rise_e) || (q.mode[cca_pkg::MM_FALL] && fall_e)) begin
          {d.high, d.low} = count_now;
          flag_set = 1'b1;
        end
      end
      cca_pkg::M_TIMER: begin
        flag_set = eq16;
      end
      cca_pkg::M_HSO: begin
        if (eq16) begin
          d.pin = !q.pin;
          flag_set = 1'b1;
        end
      end
      cca_pkg::M_FREQ: begin
        if (eq8) begin
          d.pin = !q.pin;
          // a zero step wraps the byte fully: 256 counter ticks per half-period
          d.low = 8'(q.low + q.high);
        end
      end
      cca_pkg::M_PWM8: begin
        if (wrap8) begin
          d.low = q.high;
          // zero reload matches at once, so the pin stays high: full duty
          d.pin = (q.high == cca_pkg::RESET_BYTE);
          flag_set = (q.high == cca_pkg::RESET_BYTE);
        end else if (eq8) begin
          d.pin = 1'b1;
          flag_set = 1'b1;
        end
      end
      cca_pkg::M_PWM16: begin
        if (eq16) begin
          d.pin = 1'b1;
          flag_set = 1'b1;
        end else if (wrap16) begin
          d.pin = 1'b0;
        end
      end
      default: begin
      end
    endcase
    d.oe = (m == cca_pkg::M_HSO) || (m == cca_pkg::M_FREQ)
        || (m == cca_pkg::M_PWM8) || (m == cca_pkg::M_PWM16);
    // software writes override hardware reloads in the same cycle
    if (wr_mode) begin
      d.mode = wdata;
    end
    if (wr_low) begin
      d.low = wdata;
      d.mode[cca_pkg::MM_ECOM] = 1'b0;
    end
    if (wr_high) begin
      d.high = wdata;
      d.mode[cca_pkg::MM_ECOM] = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '0;
    end else if (ce) begin
      q <= d;
    end
  end

  assign mode = q.mode;
  assign cmp_low = q.low;
  assign cmp_high = q.high;
  assign pin_out = q.pin;
  assign pin_oe = q.oe;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_capture_load;
    @(posedge aclk) disable iff (!aresetn)
      ce && m == cca_pkg::M_CAPTURE && q.mode[cca_pkg::MM_RISE] && rise_e && !wr_low && !wr_high
      |=> {cmp_high, cmp_low} == $past(count_now);
  endproperty
  a_capture_load: assert property (p_capture_load) else $error("capture value not loaded");

  property p_low_write_ecom;
    @(posedge aclk) disable iff (!aresetn)
      ce && wr_low && !wr_high |=> !mode[cca_pkg::MM_ECOM] && cmp_low == $past(wdata);
  endproperty
  a_low_write_ecom: assert property (p_low_write_ecom) else $error("low write kept compare on");

  property p_hso_toggle;
    @(posedge aclk) disable iff (!aresetn)
      ce && m == cca_pkg::M_HSO && eq16 |=> pin_out != $past(pin_out);
  endproperty
  a_hso_toggle: assert property (p_hso_toggle) else $error("pin did not toggle on match");

  property p_pwm8_reload;
    @(posedge aclk) disable iff (!aresetn)
      ce && m == cca_pkg::M_PWM8 && wrap8 && !wr_low |=> cmp_low == $past(cmp_high);
  endproperty
  a_pwm8_reload: assert property (p_pwm8_reload) else $error("pwm low byte not reloaded");

endmodule : cc_channel

// *** hdl/cca_pkg.sv ***
// counter array package: register map, field positions, timebase codes,
// module mode decoding and address decoding.
// assumes a byte-wide register file behind a 32-bit bus, one word per register.
package cca_pkg;

  // ----------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------
  localparam int N_MODULES = 6;
  localparam int ADDR_W = 8;

  // ----------------------------------------------------------------
  // register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_MODE = 8'h04;
  localparam logic [7:0] ADDR_CNT_LO = 8'h08;
  localparam logic [7:0] ADDR_CNT_HI = 8'h0C;
  localparam logic [7:0] ADDR_IEN = 8'h10;
  // module n sits in row (MOD_ROW_BASE + n) of 16 bytes
  localparam logic [3:0] MOD_ROW_BASE = 4'h2;

  // field ids returned by decode_addr
  localparam logic [2:0] F_CTRL = 3'h0;
  localparam logic [2:0] F_MODE = 3'h1;
  localparam logic [2:0] F_CNT_LO = 3'h2;
  localparam logic [2:0] F_CNT_HI = 3'h3;
  localparam logic [2:0] F_IEN = 3'h4;
  localparam logic [2:0] MOD_F_MODE = 3'h0;
  localparam logic [2:0] MOD_F_LOW = 3'h1;
  localparam logic [2:0] MOD_F_HIGH = 3'h2;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int CTRL_OVF_BIT = 7;
  localparam int CTRL_RUN_BIT = 6;
  localparam int CTRL_FLAGS_LSB = 0;
  localparam int MODE_IDLE_BIT = 7;
  localparam int MODE_TB_LSB = 1;
  localparam int MODE_OVF_IE_BIT = 0;
  localparam int IEN_GLOBAL_BIT = 7;
  localparam int IEN_ARRAY_BIT = 3;
  localparam int MM_WIDE = 7;
  localparam int MM_ECOM = 6;
  localparam int MM_RISE = 5;
  localparam int MM_FALL = 4;
  localparam int MM_MATCH = 3;
  localparam int MM_TOG = 2;
  localparam int MM_PWM = 1;
  localparam int MM_FIE = 0;

  // ----------------------------------------------------------------
  // timebase
  // ----------------------------------------------------------------
  localparam logic [2:0] TB_DIV12 = 3'h0;
  localparam logic [2:0] TB_DIV4 = 3'h1;
  localparam logic [2:0] TB_T0 = 3'h2;
  localparam logic [2:0] TB_ECI = 3'h3;
  localparam logic [2:0] TB_SYS = 3'h4;
  localparam logic [2:0] TB_OSC8 = 3'h5;
  localparam int DIV12 = 12;
  localparam int DIV4 = 4;
  localparam int OSC_DIV = 8;
  localparam logic [3:0] DIV12_LAST = 4'(DIV12 - 1);
  localparam logic [1:0] DIV4_LAST = 2'(DIV4 - 1);
  localparam logic [2:0] OSC_DIV_LAST = 3'(OSC_DIV - 1);

  localparam logic [15:0] COUNT_TOP = 16'hFFFF;
  localparam logic [7:0] LOW_TOP = 8'hFF;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // types and decoders
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    M_OFF, M_CAPTURE, M_TIMER, M_HSO, M_FREQ, M_PWM8, M_PWM16
  } cc_mode_t;

  typedef struct packed {
    logic hit;
    logic glb;
    logic [2:0] idx;
    logic [2:0] fld;
  } sel_t;

  function automatic cc_mode_t decode_mode(input logic [7:0] m);
    if (!m[MM_MATCH] && !m[MM_TOG] && !m[MM_PWM] && (m[MM_RISE] || m[MM_FALL])) return M_CAPTURE;
    if (!m[MM_ECOM] || m[MM_RISE] || m[MM_FALL]) return M_OFF;
    case ({m[MM_MATCH], m[MM_TOG], m[MM_PWM]})
      3'b100: return M_TIMER;
      3'b110: return M_HSO;
      3'b011: return M_FREQ;
      3'b001: return m[MM_WIDE] ? M_PWM16 : M_PWM8;
      default: return M_OFF;
    endcase
  endfunction : decode_mode

  function automatic sel_t decode_addr(input logic [7:0] a);
    sel_t s;
    logic [3:0] row;
    s = '0;
    row = 4'(a[7:4] - MOD_ROW_BASE);
    case (a)
      ADDR_CTRL: s = '{1'b1, 1'b1, 3'h0, F_CTRL};
      ADDR_MODE: s = '{1'b1, 1'b1, 3'h0, F_MODE};
      ADDR_CNT_LO: s = '{1'b1, 1'b1, 3'h0, F_CNT_LO};
      ADDR_CNT_HI: s = '{1'b1, 1'b1, 3'h0, F_CNT_HI};
      ADDR_IEN: s = '{1'b1, 1'b1, 3'h0, F_IEN};
      default: begin
        if (a[1:0] == 2'b00 && a[7:4] >= MOD_ROW_BASE && row < 4'(N_MODULES)
            && {1'b0, a[3:2]} <= MOD_F_HIGH) begin
          s = '{1'b1, 1'b0, row[2:0], {1'b0, a[3:2]}};
        end
      end
    endcase
    return s;
  endfunction : decode_addr

endpackage : cca_pkg

// *** hdl/counter_array.sv ***
// counter array top: shared 16-bit counter with selectable timebase, six
// capture/compare modules and an AXI4-Lite register slave.
// assumes timer0_overflow and cpu_idle come from logic on aclk; count,
// oscillator and module pins are asynchronous and are synchronised here.
module counter_array (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic awvalid,
  output logic awready,
  input wire logic [cca_pkg::ADDR_W-1:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  input wire logic arvalid,
  output logic arready,
  input wire logic [cca_pkg::ADDR_W-1:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  input wire logic cpu_idle,
  input wire logic timer0_overflow,
  input wire logic external_count_input,
  input wire logic external_osc,
  input wire logic [cca_pkg::N_MODULES-1:0] module_pin_in,
  output logic [cca_pkg::N_MODULES-1:0] module_pin_out,
  output logic [cca_pkg::N_MODULES-1:0] module_pin_oe,
  output logic irq_request
);

  localparam int N = cca_pkg::N_MODULES;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic aw_full;
    logic [cca_pkg::ADDR_W-1:0] aw_addr;
    logic w_full;
    logic [7:0] w_data;
    logic w_lane0;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [7:0] rdata;
    logic [15:0] count;
    logic [7:0] snap;
    logic run;
    logic ovf_flag;
    logic [N-1:0] mod_flag;
    logic idle_stop;
    logic [2:0] tbsel;
    logic ovf_ie;
    logic gie;
    logic aie;
    logic [3:0] div;
    logic eci_prev;
    logic osc_prev;
    logic [2:0] osc_div;
    logic irq;
  } core_t;

  core_t q;
  core_t d;

  logic eci_s;
  logic osc_s;
  logic [N-1:0] pin_s;
  logic src_tick;
  logic tick;
  logic ovf_set;
  logic [15:0] count_next;
  logic do_write;
  logic ctrl_write;
  logic [7:0] rd;
  logic [N-1:0] fie;
  cca_pkg::sel_t wsel;
  cca_pkg::sel_t rsel;
  logic [N-1:0] wr_mode;
  logic [N-1:0] wr_low;
  logic [N-1:0] wr_high;
  logic [N-1:0] flag_set;
  logic [7:0] ch_mode [N];
  logic [7:0] ch_low [N];
  logic [7:0] ch_high [N];

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  // levels shorter than one clock may be missed by these flops
  bit_sync #(
    .WIDTH(N + 2)
  ) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .din({external_osc, external_count_input, module_pin_in}),
    .dout({osc_s, eci_s, pin_s})
  );

  // ----------------------------------------------------------------
  // capture/compare modules
  // ----------------------------------------------------------------
  for (genvar g = 0; g < N; g++) begin : g_mod
    cc_channel u_ch (
      .aclk(aclk),
      .aresetn(aresetn),
      .ce(ce),
      .tick(tick),
      .count_now(q.count),
      .count_next(count_next),
      .pin_in(pin_s[g]),
      .wr_mode(wr_mode[g]),
      .wr_low(wr_low[g]),
      .wr_high(wr_high[g]),
      .wdata(q.w_data),
      .mode(ch_mode[g]),
      .cmp_low(ch_low[g]),
      .cmp_high(ch_high[g]),
      .pin_out(module_pin_out[g]),
      .pin_oe(module_pin_oe[g]),
      .flag_set(flag_set[g])
    );
    assign fie[g] = ch_mode[g][cca_pkg::MM_FIE];
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    d = q;
    wr_mode = '0;
    wr_low = '0;
    wr_high = '0;
    rd = cca_pkg::RESET_BYTE;
    ctrl_write = 1'b0;
    wsel = cca_pkg::decode_addr(q.aw_addr);
    rsel = cca_pkg::decode_addr(araddr);

    // timebase: one free prescaler serves both /12 and /4
    d.div = (q.div == cca_pkg::DIV12_LAST) ? 4'h0 : 4'(q.div + 4'h1);
    d.eci_prev = eci_s;
    d.osc_prev = osc_s;
    if (osc_s && !q.osc_prev) begin
      d.osc_div = 3'(q.osc_div + 3'h1);
    end
    case (q.tbsel)
      cca_pkg::TB_DIV12: src_tick = q.div == cca_pkg::DIV12_LAST;
      cca_pkg::TB_DIV4: src_tick = q.div[1:0] == cca_pkg::DIV4_LAST;
      cca_pkg::TB_T0: src_tick = timer0_overflow;
      cca_pkg::TB_ECI: src_tick = q.eci_prev && !eci_s;
      cca_pkg::TB_SYS: src_tick = 1'b1;
      cca_pkg::TB_OSC8: src_tick = osc_s && !q.osc_prev && q.osc_div == cca_pkg::OSC_DIV_LAST;
      default: src_tick = 1'b0;
    endcase
    tick = src_tick && q.run && !(cpu_idle && q.idle_stop);
    count_next = 16'(q.count + 16'h0001);
    if (tick) begin
      d.count = count_next;
    end
    ovf_set = tick && q.count == cca_pkg::COUNT_TOP;

    // write path: address and data may arrive in either order
    do_write = q.aw_full && q.w_full && !q.bvalid;
    if (do_write) begin
      d.aw_full = 1'b0;
      d.w_full = 1'b0;
      d.bvalid = 1'b1;
      d.bresp = wsel.hit ? cca_pkg::RESP_OKAY : cca_pkg::RESP_SLVERR;
      if (wsel.hit && q.w_lane0) begin
        if (wsel.glb) begin
          case (wsel.fld)
            cca_pkg::F_CTRL: begin
              ctrl_write = 1'b1;
              d.run = q.w_data[cca_pkg::CTRL_RUN_BIT];
              d.ovf_flag = q.w_data[cca_pkg::CTRL_OVF_BIT];
              d.mod_flag = q.w_data[cca_pkg::CTRL_FLAGS_LSB +: N];
            end
            cca_pkg::F_MODE: begin
              d.idle_stop = q.w_data[cca_pkg::MODE_IDLE_BIT];
              d.tbsel = q.w_data[cca_pkg::MODE_TB_LSB +: 3];
              d.ovf_ie = q.w_data[cca_pkg::MODE_OVF_IE_BIT];
            end
            cca_pkg::F_CNT_LO: d.count[7:0] = q.w_data;
            cca_pkg::F_CNT_HI: d.count[15:8] = q.w_data;
            cca_pkg::F_IEN: begin
              d.gie = q.w_data[cca_pkg::IEN_GLOBAL_BIT];
              d.aie = q.w_data[cca_pkg::IEN_ARRAY_BIT];
            end
            default: begin
            end
          endcase
        end else begin
          case (wsel.fld)
            cca_pkg::MOD_F_MODE: wr_mode[wsel.idx] = 1'b1;
            cca_pkg::MOD_F_LOW: wr_low[wsel.idx] = 1'b1;
            cca_pkg::MOD_F_HIGH: wr_high[wsel.idx] = 1'b1;
            default: begin
            end
          endcase
        end
      end
    end
    if (q.bvalid && bready) begin
      d.bvalid = 1'b0;
    end
    if (awvalid && q.awready) begin
      d.aw_full = 1'b1;
      d.aw_addr = awaddr;
    end
    if (wvalid && q.wready) begin
      d.w_full = 1'b1;
      d.w_data = wdata[7:0];
      d.w_lane0 = wstrb[0];
    end
    d.awready = !d.aw_full && !d.bvalid;
    d.wready = !d.w_full && !d.bvalid;

    // read path: data is muxed on the handshake edge
    if (rsel.glb) begin
      case (rsel.fld)
        cca_pkg::F_CTRL: rd = {q.ovf_flag, q.run, q.mod_flag};
        cca_pkg::F_MODE: rd = {q.idle_stop, 3'b000, q.tbsel, q.ovf_ie};
        cca_pkg::F_CNT_LO: rd = q.count[7:0];
        cca_pkg::F_CNT_HI: rd = q.snap;
        cca_pkg::F_IEN: begin
          rd[cca_pkg::IEN_GLOBAL_BIT] = q.gie;
          rd[cca_pkg::IEN_ARRAY_BIT] = q.aie;
        end
        default: begin
        end
      endcase
    end else if (rsel.hit) begin
      case (rsel.fld)
        cca_pkg::MOD_F_MODE: rd = ch_mode[rsel.idx];
        cca_pkg::MOD_F_LOW: rd = ch_low[rsel.idx];
        cca_pkg::MOD_F_HIGH: rd = ch_high[rsel.idx];
        default: begin
        end
      endcase
    end
    if (q.rvalid && rready) begin
      d.rvalid = 1'b0;
    end
    if (arvalid && q.arready) begin
      d.rvalid = 1'b1;
      d.rdata = rd;
      d.rresp = rsel.hit ? cca_pkg::RESP_OKAY : cca_pkg::RESP_SLVERR;
      if (rsel.glb && rsel.fld == cca_pkg::F_CNT_LO) begin
        d.snap = q.count[15:8];
      end
    end
    d.arready = !d.rvalid;

    // hardware set wins over a software clear in the same cycle
    d.ovf_flag = d.ovf_flag || ovf_set;
    d.mod_flag = d.mod_flag | flag_set;
    d.irq = q.gie && q.aie
        && ((q.ovf_flag && q.ovf_ie) || |(q.mod_flag & fie));
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '0;
    end else if (ce) begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign awready = q.awready;
  assign wready = q.wready;
  assign bvalid = q.bvalid;
  assign bresp = q.bresp;
  assign arready = q.arready;
  assign rvalid = q.rvalid;
  assign rresp = q.rresp;
  assign rdata = {24'h00_0000, q.rdata};
  assign irq_request = q.irq;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_div12_spacing;
    @(posedge aclk) disable iff (!aresetn)
      ce && q.tbsel == cca_pkg::TB_DIV12 && src_tick ##1 (ce && q.tbsel == cca_pkg::TB_DIV12) [*8]
      |-> !src_tick;
  endproperty
  a_div12_spacing: assert property (p_div12_spacing) else $error("div12 ticks too close");

  property p_snapshot;
    @(posedge aclk) disable iff (!aresetn)
      ce && arvalid && arready && rsel.glb && rsel.fld == cca_pkg::F_CNT_LO
      |=> q.snap == $past(q.count[15:8]) && rdata[7:0] == $past(q.count[7:0]);
  endproperty
  a_snapshot: assert property (p_snapshot) else $error("low read did not snapshot high");

  property p_overflow_flag;
    @(posedge aclk) disable iff (!aresetn)
      ce && tick && q.count == cca_pkg::COUNT_TOP |=> q.ovf_flag && q.count == 16'h0000;
  endproperty
  a_overflow_flag: assert property (p_overflow_flag) else $error("wrap did not set flag");

  property p_flags_sticky;
    @(posedge aclk) disable iff (!aresetn)
      ce && !ctrl_write |=> (q.ovf_flag || !$past(q.ovf_flag)) && (&(q.mod_flag | ~$past(q.mod_flag)));
  endproperty
  a_flags_sticky: assert property (p_flags_sticky) else $error("flag cleared by hardware");

  property p_irq_gate;
    @(posedge aclk) disable iff (!aresetn)
      irq_request |-> $past(q.gie) && $past(q.aie);
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("request without enables");

  property p_count_step;
    @(posedge aclk) disable iff (!aresetn)
      ce && tick && !do_write |=> q.count == 16'($past(q.count) + 16'h0001);
  endproperty
  a_count_step: assert property (p_count_step) else $error("counter did not step");

  property p_idle_hold;
    @(posedge aclk) disable iff (!aresetn)
      ce && cpu_idle && q.idle_stop && !do_write |=> $stable(q.count);
  endproperty
  a_idle_hold: assert property (p_idle_hold) else $error("counter moved in stopped idle");

endmodule : counter_array

// *** verification/counter_array_test.sv ***
// bench: counting, snapshot, overflow, enables, capture.
// assumes the partner pins model in ext_pins.
module counter_array_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic aclk = 1'b0, aresetn = 1'b0, ce = 1'b1, en = 1'b0;
  logic cpu_idle = 1'b0, timer0_overflow = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, irq_request;
  logic external_count_input, external_osc;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000, rdata;
  logic [3:0] wstrb = 4'h1;
  logic [1:0] bresp, rresp;
  logic [5:0] lvl = 6'h00, module_pin_in, module_pin_out, module_pin_oe;
  logic [16:0] c;
  int n_fail = 0, checks_done = 0, seed = 39504, k, m;
  always #50 aclk = ~aclk;
  counter_array dut (.aclk, .aresetn, .ce, .awvalid, .awready, .awaddr, .wvalid, .wready,
    .wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .rvalid,
    .rready, .rdata, .rresp, .cpu_idle, .timer0_overflow, .external_osc,
    .external_count_input, .module_pin_in, .module_pin_out, .module_pin_oe, .irq_request);
  ext_pins far (.aclk, .en, .lvl, .external_count_input, .external_osc, .module_pin_in);
  // ----
  // tasks
  // ----
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge aclk);
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    awaddr <= a;
    wdata <= {24'h00_0000, d};
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [1:0] er, input logic [7:0] ex);
    @(posedge aclk);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rready <= 1'b0;
    chk({30'h0, rresp}, {30'h0, er});
    chk(rdata, {24'h00_0000, ex});
  endtask : rd
  task automatic irq_is(input logic e);
    repeat (2) @(posedge aclk);
    chk({31'h0, irq_request}, {31'h0, e});
  endtask : irq_is
  task automatic report_and_stop();
    $display("checks_done=%0d n_fail=%0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : report_and_stop
  initial begin
    #(100 * 20000);
    n_fail++;
    report_and_stop();
  end
  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    rd(8'h00, 2'h0, 8'h00);
    rd(8'h14, 2'h2, 8'h00);
    wr(8'h04, 8'h07);
    wr(8'h10, 8'h88);
    // second pass starts just below the wrap
    for (int i = 0; i < 2; i++) begin
      k = 1 + $unsigned($random(seed)) % 8;
      c = (i == 0) ? 17'($random(seed) & 32'h7FFF) : 17'h1_0000 - 17'(k);
      wr(8'h08, c[7:0]);
      wr(8'h0C, c[15:8]);
      wr(8'h00, 8'h40);
      en <= 1'b1;
      repeat (6 * k) @(posedge aclk);
      en <= 1'b0;
      repeat (8) @(posedge aclk);
      c = c + 17'(k);
      rd(8'h08, 2'h0, c[7:0]);
      rd(8'h0C, 2'h0, c[15:8]);
      rd(8'h00, 2'h0, {c[16], 7'h40});
      irq_is(c[16]);
    end
    wr(8'h10, 8'h80);
    irq_is(1'b0);
    wr(8'h10, 8'h88);
    irq_is(1'b1);
    wr(8'h00, 8'h40);
    irq_is(1'b0);
    m = $unsigned($random(seed)) % 6;
    c = 17'($random(seed) & 32'hFFFF);
    wr(8'h08, c[7:0]);
    wr(8'h0C, c[15:8]);
    wr(8'(8'h20 + 16 * m), 8'h21);
    lvl[m] <= 1'b1;
    repeat (8) @(posedge aclk);
    rd(8'(8'h24 + 16 * m), 2'h0, c[7:0]);
    rd(8'(8'h28 + 16 * m), 2'h0, c[15:8]);
    rd(8'h00, 2'h0, 8'h40 | (8'h01 << m));
    irq_is(1'b1);
    // idle with idle stop set freezes the count at 0x1000
    cpu_idle <= 1'b1;
    wr(8'h04, 8'h88);
    wr(8'h08, 8'h00);
    wr(8'h0C, 8'h10);
    wr(8'h00, 8'h40);
    // high-speed output on another module, compare at 0x1014
    k = (m + 1) % 6;
    wr(8'(8'h20 + 16 * k), 8'h4C);
    wr(8'(8'h24 + 16 * k), 8'h14);
    rd(8'(8'h20 + 16 * k), 2'h0, 8'h0C);
    wr(8'(8'h28 + 16 * k), 8'h10);
    rd(8'(8'h20 + 16 * k), 2'h0, 8'h4C);
    rd(8'h08, 2'h0, 8'h00);
    chk({26'h0, module_pin_oe}, 32'h1 << k);
    // idle stop cleared: the count must run on while the cpu idles
    wr(8'h04, 8'h08);
    repeat (40) @(posedge aclk);
    wr(8'h04, 8'h88);
    chk({26'h0, module_pin_out}, 32'h1 << k);
    rd(8'h00, 2'h0, 8'h40 | (8'h01 << k));
    // timer 0 timebase: one overflow pulse, one count
    wr(8'h04, 8'h04);
    wr(8'h08, 8'h00);
    timer0_overflow <= 1'b1;
    @(posedge aclk);
    timer0_overflow <= 1'b0;
    repeat (2) @(posedge aclk);
    rd(8'h08, 2'h0, 8'h01);
    report_and_stop();
  end
endmodule : counter_array_test

// *** verification/ext_pins.sv ***
// far-side pins: count input, oscillator and capture lines.
// assumes en is held for whole six-clock windows.
module ext_pins (
  input wire logic aclk,
  input wire logic en,
  input wire logic [5:0] lvl,
  output logic external_count_input,
  output logic external_osc,
  output logic [5:0] module_pin_in
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] p_q = 3'h0;
  initial external_count_input = 1'b1;
  initial external_osc = 1'b0;
  initial module_pin_in = 6'h00;
  // half the system rate, so never faster than it
  always @(posedge aclk) external_osc <= ~external_osc;
  // three high, three low: one fall per six clocks
  always @(posedge aclk) begin
    p_q <= (!en || p_q == 3'h5) ? 3'h0 : p_q + 3'h1;
    external_count_input <= !en || p_q < 3'h2 || p_q == 3'h5;
    module_pin_in <= lvl;
  end
endmodule : ext_pins
